// *** rtl/ppof_pkg.sv ***
package ppof_pkg;
  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ROT_EN = 2;
  localparam int CTRL_ROT_OPT = 3;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CTRL_DUAL = 7;
  localparam int CTRL_FETCH_EN = 8;
  // status register fields
  localparam int STAT_ROT_OK = 0;
  localparam int STAT_SCALE_OK = 1;
  localparam int STAT_STREAMS_LSB = 2;
  localparam int STAT_FBUSY = 4;
  localparam int STAT_LOCK = 5;
  localparam int STAT_RATE_LSB = 8;
  // panel bus modes
  localparam logic [1:0] MODE_24 = 2'h0;
  localparam logic [1:0] MODE_18 = 2'h1;
  localparam logic [1:0] MODE_16 = 2'h2;
  localparam logic [1:0] MODE_12 = 2'h3;
  // source layouts
  localparam logic [2:0] FMT_AYUV32 = 3'h0;
  localparam logic [2:0] FMT_422PK = 3'h1;
  localparam logic [2:0] FMT_422SP = 3'h2;
  localparam logic [2:0] FMT_422PL = 3'h3;
  localparam logic [2:0] FMT_420SP = 3'h4;
  localparam logic [2:0] FMT_420PL = 3'h5;
  // sustained fetch rates in hundredths of a pixel per cycle
  localparam logic [8:0] RATE_BURST_422 = 9'h0C8;
  localparam logic [8:0] RATE_BURST_420 = 9'h10A;
  localparam logic [8:0] RATE_BURST_DUAL = 9'h190;
  localparam logic [8:0] RATE_ONE = 9'h064;
  localparam logic [8:0] RATE_FIFTH = 9'h014;
  localparam logic [8:0] RATE_0P66 = 9'h042;
  localparam logic [8:0] RATE_0P132 = 9'h00D;
  localparam logic [8:0] RATE_0P5 = 9'h032;
  localparam logic [8:0] RATE_0P1 = 9'h00A;
  localparam logic [8:0] RATE_0P8 = 9'h050;
  localparam logic [8:0] RATE_0P16 = 9'h010;
  localparam logic [8:0] RATE_NONE = 9'h000;
  // fetch sequencer states
  typedef enum logic [2:0] {
    F_IDLE = 3'b001,
    F_BURST = 3'b010,
    F_SINGLE = 3'b100
  } ppof_fstate_e;
endpackage : ppof_pkg

// *** rtl/ppof_buf.sv ***
`timescale 1ns/10ps
module ppof_buf #(
  parameter int W = 24
) (
  // clocking
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // fill side
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  // drain side
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [W-1:0] slot [2];
  logic wptr;
  logic rptr;
  logic [1:0] cnt;
  logic push;
  logic pop;
  logic [1:0] next_cnt;

  // handshakes only count while the clock enable is high
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;
  assign out_valid_o = (cnt != 2'h0);
  assign out_data_o = slot[rptr];

  // occupancy after this cycle
  always_comb begin
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'h1;
    end
  end

  // pointers, count and registered ready
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      cnt <= 2'h0;
      in_ready_o <= 1'b0;
    end else if (ce_i) begin
      if (push) begin
        wptr <= ~wptr;
      end
      if (pop) begin
        rptr <= ~rptr;
      end
      cnt <= next_cnt;
      in_ready_o <= (next_cnt != 2'h2); // ready stays honest one cycle ahead
    end
  end

  // storage, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      slot[wptr] <= in_data_i;
    end
  end
endmodule : ppof_buf

// *** rtl/ppof_top.sv ***
// Behaviour
// - 24-bit mode puts R8 on lines 23-16, G8 15-8, B8 7-0.
// - 18-bit mode puts R6 on lines 17-12, G6 11-6, B6 5-0.
// - 16-bit mode puts R5 on lines 15-11, G6 10-5, B5 4-0.
// - 12-bit mode puts R4 on lines 11-8, G4 7-4, B4 3-0.
// - rotation optimisation keeps the bus lock across consecutive single reads.
// - packed 4:2:2 never rotates but scales; packed alpha YUV does both.
// - semiplanar fetches two streams, planar three; rotation and scaling stay.
// - one port burst rate is 2 px/cycle at 4:2:2, 2.66 at 4:2:0.
// - two ports give 4 burst for semiplanar and planar layouts, 1 optimised, 0.2 normal rotation.
`timescale 1ns/10ps
module ppof_top
  import ppof_pkg::*;
(
  // clocking
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // pixel stream in
  input wire logic [7:0] pix_r_i,
  input wire logic [7:0] pix_g_i,
  input wire logic [7:0] pix_b_i,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  // panel pins
  output logic [23:0] panel_data_lines_o,
  output logic panel_valid_o,
  input wire logic panel_ready_i,
  // fetch request port
  output logic fetch_req_o,
  output logic [1:0] fetch_stream_o,
  output logic fetch_lock_o,
  output logic fetch_burst_o,
  input wire logic fetch_gnt_i
);
  logic [DATA_W-1:0] ctrl;
  logic [1:0] mode;
  logic [2:0] fmt;
  logic rot_en;
  logic rot_opt;
  logic dual;
  logic fetch_en;
  logic rot_ok;
  logic [1:0] streams;
  logic [8:0] rate;
  logic [2:0] rdy_sync;
  logic rdy_s;
  logic [23:0] bo_data;
  logic bo_valid;
  logic bo_ready;
  logic load;
  logic [23:0] next_lines;
  ppof_fstate_e fstate;
  ppof_fstate_e next_fstate;
  logic [DATA_W-1:0] stat;

  assign mode = ctrl[CTRL_MODE_LSB +: 2];
  assign fmt = ctrl[CTRL_FMT_LSB +: 3];
  assign rot_en = ctrl[CTRL_ROT_EN];
  assign rot_opt = ctrl[CTRL_ROT_OPT];
  assign dual = ctrl[CTRL_DUAL];
  assign fetch_en = ctrl[CTRL_FETCH_EN];

  // packed 4:2:2 has no rotation path at all
  assign rot_ok = (fmt != FMT_422PK);

  // memory streams per layout
  always_comb begin
    unique case (fmt)
      FMT_422SP, FMT_420SP: streams = 2'h2;
      FMT_422PL, FMT_420PL: streams = 2'h3;
      default: streams = 2'h1;
    endcase
  end

  // sustained rate for the selected layout, port count and access mode
  always_comb begin
    rate = RATE_NONE;
    if (!(rot_en && rot_ok)) begin
      unique case (fmt)
        FMT_422SP, FMT_422PL: rate = dual ? RATE_BURST_DUAL : RATE_BURST_422;
        FMT_420SP, FMT_420PL: rate = dual ? RATE_BURST_DUAL : RATE_BURST_420;
        FMT_422PK: rate = RATE_BURST_422;
        default: rate = RATE_ONE;
      endcase
    end else if (dual && streams != 2'h1) begin
      rate = rot_opt ? RATE_ONE : RATE_FIFTH;
    end else begin
      unique case (fmt)
        FMT_422SP, FMT_420PL: rate = rot_opt ? RATE_0P66 : RATE_0P132;
        FMT_422PL: rate = rot_opt ? RATE_0P5 : RATE_0P1;
        FMT_420SP: rate = rot_opt ? RATE_0P8 : RATE_0P16;
        default: rate = rot_opt ? RATE_ONE : RATE_FIFTH;
      endcase
    end
  end

  // control register, written by software
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RESET;
    end else if (ce_i && reg_wr_i && reg_addr_i == OFS_CTRL) begin
      ctrl <= {23'h00000, reg_wdata_i[8:0]};
    end
  end

  // status word, live state except the constant scale bit
  always_comb begin
    stat = 32'h00000000;
    stat[STAT_ROT_OK] = rot_ok;
    stat[STAT_SCALE_OK] = 1'b1; // every layout scales
    stat[STAT_STREAMS_LSB +: 2] = streams;
    stat[STAT_FBUSY] = fetch_req_o;
    stat[STAT_LOCK] = fetch_lock_o;
    stat[STAT_RATE_LSB +: 9] = rate;
  end

  // read data stand one cycle after the strobe only; unmapped reads zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      if (reg_rd_i && reg_addr_i == OFS_CTRL) begin
        reg_rdata_o <= ctrl;
      end else if (reg_rd_i && reg_addr_i == OFS_STAT) begin
        reg_rdata_o <= stat;
      end else begin
        reg_rdata_o <= 32'h00000000;
      end
    end
  end

  // panel ready is a pin: three stages, act when the last two agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_sync <= 3'h0;
      rdy_s <= 1'b0;
    end else if (ce_i) begin
      rdy_sync <= {rdy_sync[1:0], panel_ready_i};
      if (rdy_sync[1] == rdy_sync[2]) begin
        rdy_s <= rdy_sync[2];
      end
    end
  end

  // two-entry buffer so a panel stall never drops a pixel
  ppof_buf #(.W(24)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_data_i({pix_r_i, pix_g_i, pix_b_i}),
    .in_valid_i(pix_valid_i),
    .in_ready_o(pix_ready_o),
    .out_data_o(bo_data),
    .out_valid_o(bo_valid),
    .out_ready_i(bo_ready)
  );

  assign bo_ready = rdy_s || !panel_valid_o;
  assign load = ce_i && bo_valid && bo_ready;

  // lane mapping per panel mode; unused lines stay low
  always_comb begin
    next_lines = 24'h000000;
    unique case (mode)
      MODE_24: next_lines = bo_data;
      MODE_18: next_lines[17:0] = {bo_data[23:18], bo_data[15:10], bo_data[7:2]};
      MODE_16: next_lines[15:0] = {bo_data[23:19], bo_data[15:10], bo_data[7:3]};
      MODE_12: next_lines[11:0] = {bo_data[23:20], bo_data[15:12], bo_data[7:4]};
    endcase
  end

  // panel output register; last word holds until the panel takes it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      panel_data_lines_o <= 24'h000000;
      panel_valid_o <= 1'b0;
    end else if (ce_i) begin
      if (load) begin
        panel_data_lines_o <= next_lines;
        panel_valid_o <= 1'b1;
      end else if (rdy_s) begin
        panel_valid_o <= 1'b0;
      end
    end
  end

  // fetch sequencer: burst unless rotation is active and allowed
  always_comb begin
    next_fstate = fstate;
    unique case (fstate)
      F_IDLE: begin
        if (fetch_en) begin
          next_fstate = (rot_en && rot_ok) ? F_SINGLE : F_BURST;
        end
      end
      F_BURST, F_SINGLE: begin
        if (!fetch_en) begin
          next_fstate = F_IDLE;
        end
      end
      default: next_fstate = F_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fstate <= F_IDLE;
    end else if (ce_i) begin
      fstate <= next_fstate;
    end
  end

  // request outputs; stream index walks Y, then chroma streams
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_req_o <= 1'b0;
      fetch_stream_o <= 2'h0;
      fetch_lock_o <= 1'b0;
      fetch_burst_o <= 1'b0;
    end else if (ce_i) begin
      fetch_req_o <= (next_fstate != F_IDLE);
      fetch_burst_o <= (next_fstate == F_BURST);
      // lock held through consecutive single reads, not dropped between
      fetch_lock_o <= (next_fstate == F_SINGLE) && rot_opt;
      if (next_fstate == F_IDLE) begin
        fetch_stream_o <= 2'h0;
      end else if (fetch_req_o && fetch_gnt_i) begin
        fetch_stream_o <= (fetch_stream_o + 2'h1 >= streams) ? 2'h0 : fetch_stream_o + 2'h1;
      end
    end
  end

  property p_map24;
    @(posedge clk_i) disable iff (rst_i)
    load && mode == MODE_24 |=> panel_data_lines_o == $past(bo_data);
  endproperty
  a_map24: assert property (p_map24) else $error("24-bit lane map wrong");

  property p_map18;
    @(posedge clk_i) disable iff (rst_i)
    load && mode == MODE_18 |=> panel_data_lines_o[17:12] == $past(bo_data[23:18])
      && panel_data_lines_o[5:0] == $past(bo_data[7:2]);
  endproperty
  a_map18: assert property (p_map18) else $error("18-bit lane map wrong");

  property p_map16;
    @(posedge clk_i) disable iff (rst_i)
    load && mode == MODE_16 |=> panel_data_lines_o[10:5] == $past(bo_data[15:10])
      && panel_data_lines_o[15:11] == $past(bo_data[23:19]);
  endproperty
  a_map16: assert property (p_map16) else $error("16-bit lane map wrong");

  property p_map12;
    @(posedge clk_i) disable iff (rst_i)
    load && mode == MODE_12 |=> panel_data_lines_o[11:8] == $past(bo_data[23:20])
      && panel_data_lines_o[3:0] == $past(bo_data[7:4]);
  endproperty
  a_map12: assert property (p_map12) else $error("12-bit lane map wrong");

  property p_lock;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && fetch_req_o && !fetch_burst_o && rot_opt && fetch_en && $stable(ctrl)
      |=> fetch_lock_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock released between single reads");

  property p_norot422;
    @(posedge clk_i) disable iff (rst_i)
    fmt == FMT_422PK && fetch_req_o |-> fetch_burst_o && !fetch_lock_o;
  endproperty
  a_norot422: assert property (p_norot422) else $error("packed 4:2:2 rotated");

  property p_streams;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && fetch_req_o && fetch_gnt_i && fetch_stream_o == 2'h1 && streams == 2'h3
      && fetch_en |=> fetch_stream_o == 2'h2;
  endproperty
  a_streams: assert property (p_streams) else $error("planar stream order wrong");

  property p_rate1;
    @(posedge clk_i) disable iff (rst_i)
    !rot_en && !dual && fmt == FMT_420PL |-> rate == RATE_BURST_420;
  endproperty
  a_rate1: assert property (p_rate1) else $error("single-port 4:2:0 rate wrong");

  property p_rate2;
    @(posedge clk_i) disable iff (rst_i)
    dual && rot_en && !rot_opt && streams != 2'h1 |-> rate == RATE_FIFTH;
  endproperty
  a_rate2: assert property (p_rate2) else $error("dual-port rotation rate wrong");

  property p_unused;
    @(posedge clk_i) disable iff (rst_i)
    load && mode == MODE_16 |=> panel_data_lines_o[23:16] == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused lines toggled");
endmodule : ppof_top

// *** bench/ppof_panel_model.sv ***
`timescale 1ns/10ps
module ppof_panel_model (
  // clocking
  input wire logic clk_i,
  // panel pins
  input wire logic [23:0] panel_data_lines_i,
  input wire logic panel_valid_i,
  output logic panel_ready_o,
  // bench control
  input wire logic stall_i,
  input wire logic slow_i
);
  logic [1:0] phase = 2'h0;
  int words = 0;
  initial panel_ready_o = 1'b0;
  // slow panel holds ready two cycles high, two low; a ready that flips
  // every cycle never settles in the design's two-stage agreement filter
  always @(posedge clk_i) begin
    phase <= phase + 2'h1;
    panel_ready_o <= !stall_i && (!slow_i || phase[1]);
    if (panel_valid_i && panel_ready_o && panel_data_lines_i !== 24'hx) begin
      words <= words + 1;
    end
  end
endmodule : ppof_panel_model

// *** bench/ppof_top_bench.sv ***
`timescale 1ns/10ps
module ppof_top_bench;
  import ppof_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [7:0] pix_r_i = 8'h00;
  logic [7:0] pix_g_i = 8'h00;
  logic [7:0] pix_b_i = 8'h00;
  logic pix_valid_i = 1'b0;
  logic pix_ready_o;
  logic [23:0] panel_data_lines_o;
  logic panel_valid_o;
  logic panel_ready_i;
  logic fetch_req_o;
  logic [1:0] fetch_stream_o;
  logic fetch_lock_o;
  logic fetch_burst_o;
  logic fetch_gnt_i = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  int num_errors = 0;
  int compares = 0;
  logic [DATA_W-1:0] rd;
  logic [23:0] px;
  logic [23:0] acc_q[$];
  bit ok;
  // rate table: control value against sustained rate
  localparam logic [8:0] CTL_TAB [9] = '{9'h010, 9'h020, 9'h040, 9'h050, 9'h0B0, 9'h0BC,
    9'h0C4, 9'h02C, 9'h044};
  localparam logic [8:0] RATE_TAB [9] = '{RATE_BURST_422, RATE_BURST_422, RATE_BURST_420,
    RATE_BURST_420, RATE_BURST_DUAL, RATE_ONE, RATE_FIFTH, RATE_0P66, RATE_0P16};
  localparam logic [1:0] STREAMS [6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3};

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  ppof_top u_ppof_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pix_r_i(pix_r_i), .pix_g_i(pix_g_i), .pix_b_i(pix_b_i),
    .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
    .panel_data_lines_o(panel_data_lines_o), .panel_valid_o(panel_valid_o),
    .panel_ready_i(panel_ready_i), .fetch_req_o(fetch_req_o),
    .fetch_stream_o(fetch_stream_o), .fetch_lock_o(fetch_lock_o),
    .fetch_burst_o(fetch_burst_o), .fetch_gnt_i(fetch_gnt_i));

  ppof_panel_model u_ppof_panel_model (.clk_i(clk_i),
    .panel_data_lines_i(panel_data_lines_o), .panel_valid_i(panel_valid_o),
    .panel_ready_o(panel_ready_i), .stall_i(stall), .slow_i(slow));

  // expected pin image: reduced modes keep the colour MSBs
  function automatic logic [23:0] map(input logic [1:0] m, input logic [23:0] c);
    case (m)
      MODE_24: map = c;
      MODE_18: map = {6'h00, c[23:18], c[15:10], c[7:2]};
      MODE_16: map = {8'h00, c[23:19], c[15:10], c[7:3]};
      default: map = {12'h000, c[23:20], c[15:12], c[7:4]};
    endcase
  endfunction : map

  task test_done;
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  task reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  // read data stands only in the cycle after the strobe
  task reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : reg_read

  // ready is sampled mid-cycle so the take edge is known without a race
  task push_pix(input logic [23:0] c, output bit taken);
    bit s;
    taken = 1'b0;
    @(posedge clk_i);
    {pix_r_i, pix_g_i, pix_b_i} <= c;
    pix_valid_i <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      @(negedge clk_i);
      s = pix_ready_o;
      @(posedge clk_i);
      if (s) begin
        taken = 1'b1;
        break;
      end
    end
    pix_valid_i <= 1'b0;
  endtask : push_pix

  task wait_word(input logic [23:0] exp);
    for (int n = 0; n < 30; n++) begin
      @(posedge clk_i);
      #1;
      if (panel_valid_o === 1'b1 && panel_data_lines_o === exp) break;
    end
    check({8'h00, panel_data_lines_o}, {8'h00, exp}, "panel word");
    check(32'(panel_valid_o), 32'h1, "panel valid");
  endtask : wait_word

  task pulse_gnt;
    @(posedge clk_i);
    fetch_gnt_i <= 1'b1;
    @(posedge clk_i);
    fetch_gnt_i <= 1'b0;
    #1;
  endtask : pulse_gnt

  task fetch_case(input logic [8:0] ctl, input logic lk, input logic bu, input int n);
    int k;
    reg_write(OFS_CTRL, 32'h100 | 32'(ctl));
    k = 0;
    while (fetch_req_o !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    check(32'(fetch_req_o), 32'h1, "fetch request");
    if (k == 20) test_done();
    check(32'(fetch_lock_o), 32'(lk), "lock");
    check(32'(fetch_burst_o), 32'(bu), "burst");
    check(32'(fetch_stream_o), 32'h0, "first stream");
    reg_read(OFS_STAT, rd);
    check(32'(rd[5:4]), 32'({lk, 1'b1}), "stat lock");
    for (int i = 1; i <= n; i++) begin
      pulse_gnt();
      check(32'(fetch_stream_o), 32'(i % n), "stream order");
      check(32'(fetch_lock_o), 32'(lk), "lock held");
    end
    reg_write(OFS_CTRL, 32'h0);
  endtask : fetch_case

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    test_done();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    reg_read(OFS_CTRL, rd);
    check(rd, CTRL_RESET, "ctrl reset");
    reg_write(4'hC, 32'hFFFFFFFF);
    reg_read(4'hC, rd);
    check(rd, 32'h0, "unmapped");
    reg_write(OFS_CTRL, 32'hFFFFFE00);
    reg_read(OFS_CTRL, rd);
    check(rd, 32'h0, "ctrl spare bits");
    @(posedge clk_i);
    ce_i <= 1'b0;
    reg_write(OFS_CTRL, 32'h3);
    ce_i <= 1'b1;
    reg_read(OFS_CTRL, rd);
    check(rd, 32'h0, "write while frozen");
    for (int f = 0; f < 6; f++) begin
      reg_write(OFS_CTRL, 32'h4 | (32'(f) << 4));
      reg_read(OFS_STAT, rd);
      check(32'(rd[0]), 32'(f != 1), "rotation allowed");
      check(32'(rd[3:1]), 32'({STREAMS[f], 1'b1}), "streams and scaling");
    end
    for (int i = 0; i < 9; i++) begin
      reg_write(OFS_CTRL, 32'(CTL_TAB[i]));
      reg_read(OFS_STAT, rd);
      check(32'(rd[16:8]), 32'(RATE_TAB[i]), "fetch rate");
    end
    stall <= 1'b0;
    // read data must fall back to zero one cycle after it stood
    @(posedge clk_i);
    #1;
    check(reg_rdata_o, 32'h0, "read data held");
    for (int m = 0; m < 4; m++) begin
      reg_write(OFS_CTRL, 32'(m));
      px = 24'hA53CF1 + 24'(m) * 24'h5A5A5;
      push_pix(px, ok);
      wait_word(map(2'(m), px));
    end
    // stalled panel: buffer must refuse, then drain in order without loss
    reg_write(OFS_CTRL, 32'h0);
    stall <= 1'b1;
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      px = 24'h13579B + 24'(i) * 24'h202020;
      push_pix(px, ok);
      if (!ok) break;
      acc_q.push_back(px);
    end
    check(32'(ok), 32'h0, "buffer refusal");
    check(32'(acc_q.size() >= 2), 32'h1, "buffer depth");
    slow <= 1'b1;
    stall <= 1'b0;
    foreach (acc_q[i]) wait_word(acc_q[i]);
    fetch_case(9'h03C, 1'b1, 1'b0, 3);
    fetch_case(9'h024, 1'b0, 1'b0, 2);
    fetch_case(9'h050, 1'b0, 1'b1, 3);
    fetch_case(9'h014, 1'b0, 1'b1, 1);
    test_done();
  end
endmodule : ppof_top_bench
